/* core/translation_unit_global_control_low.sv */
// Global configuration register, low fields, with Wishbone slave and client policy
//
// Operation
// [RULE_01] Force broadcast upgrades client maintenance operations
// [RULE_02] Force broadcast at bit 13, bypass traffic
// [RULE_03] Private maintenance gates broadcast TLB participation
// [RULE_04] Private settings are hints only
// [RULE_05] Private maintenance reads one or zero per capability
// [RULE_06] Private VMID namespace skips VMID invalidates
// [RULE_07] VMID namespace reserved in secure copy
// [RULE_08] Unmatched stream passes or faults per bit 10
// [RULE_09] Global stall enable, bit 9, reset 0
// [RULE_10] Stall disable stops stalls, masks global stall
// [RULE_11] Stall disable resets 0 with two security states
// [RULE_12] Transient hint bits 7:6 for bypass traffic
// [RULE_13] Config fault interrupt enable, bit 5
// [RULE_14] Config fault abort enable, bit 4
// [RULE_15] Extended ID format select, bit 3
// [RULE_16] Software changes extended ID after entry setup
// [RULE_17] Global fault interrupt enable, bit 2
// [RULE_18] Global fault abort enable, bit 1
// [RULE_19] Exclusive access fails when fault reporting off
// [RULE_20] Client port disable bypasses everything, resets 1
// [RULE_21] Unknown-reset fields modelled as zero
`timescale 1ns/1ps
`default_nettype none
`include "gcfg_defines.svh"

module translation_unit_global_control_low
    import gcfg_pkg::*;
#(
    parameter bit BROADCAST_MAINT_CAPABLE  = 1'b1,
    parameter bit PRIVATE_MAINT_SUPPORTED  = 1'b1,
    parameter bit PRIVATE_VMID_SUPPORTED   = 1'b1,
    parameter bit GLOBAL_STALL_SUPPORTED   = 1'b1,
    parameter bit TWO_SECURITY_STATES      = 1'b1,
    parameter bit TRANSIENT_HINT_PRESENT   = 1'b1,
    parameter bit CFG_FAULT_SUPPORTED      = 1'b1,
    parameter bit EXTENDED_ID_SUPPORTED    = 1'b1,
    parameter bit STREAM_MATCH_SUPPORTED   = 1'b1,
    parameter bit SECURE_COPY              = 1'b0
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        maint_op_valid,
    input  wire logic        maint_op_broadcast,
    input  wire logic        sys_tlbi_valid,
    input  wire logic        sys_tlbi_by_vmid,
    input  wire logic        txn_valid,
    input  wire logic        txn_stream_matched,
    input  wire logic        txn_exclusive,
    input  wire logic        context_fault,
    input  wire logic        global_fault,
    input  wire logic        cfg_fault,
    output logic             maint_op_broadcast_out,
    output logic             tlbi_apply,
    output logic             txn_bypass,
    output logic             txn_unidentified_fault,
    output logic             transient_hint_t_dummy_n,
    output logic [1:0]       transient_hint,
    output logic             global_stall,
    output logic             context_stall,
    output logic             extended_id_format,
    output logic             global_fault_irq,
    output logic             cfg_fault_irq,
    output logic             global_fault_abort,
    output logic             cfg_fault_abort,
    output logic             exclusive_fail
);

    // ------------------------------------------------------------
    // Field write masks
    // ------------------------------------------------------------
    localparam bit PTM_WRITABLE = BROADCAST_MAINT_CAPABLE && PRIVATE_MAINT_SUPPORTED;
    localparam bit PTM_FIXED    = !BROADCAST_MAINT_CAPABLE;
    localparam bit VMID_WRITABLE = BROADCAST_MAINT_CAPABLE && PRIVATE_VMID_SUPPORTED
                                   && !SECURE_COPY;
    localparam bit VMID_FIXED    = !BROADCAST_MAINT_CAPABLE && !SECURE_COPY;
    localparam bit EXT_WRITABLE  = EXTENDED_ID_SUPPORTED && STREAM_MATCH_SUPPORTED;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic             force_broadcast_q;
    logic             private_tlb_maint_q;
    logic             vmid_private_namespace_q;
    logic             unmatched_stream_fault_cfg_q;
    logic             global_stall_enable_q;
    logic             stall_disable_q;
    transient_hint_t  transient_hint_cfg_q;
    logic             cfg_fault_irq_enable_q;
    logic             cfg_fault_abort_enable_q;
    logic             extended_id_enable_q;
    logic             global_fault_irq_enable_q;
    logic             global_fault_abort_enable_q;
    logic             client_port_disable_q;
    bus_state_e       bus_q;
    logic [31:0]      rdata_d;
    logic             hit_cfg;
    logic             hit_caps;
    logic             req;
    logic             wr_cfg;

    function automatic logic merge_bit(input logic old_v, input logic new_v,
                                       input logic lane_en);
        merge_bit = lane_en ? new_v : old_v;
    endfunction : merge_bit

    assign req     = wb_cyc_i && wb_stb_i && (bus_q == BUS_IDLE);
    assign hit_cfg  = (wb_adr_i == `GCFG0_OFFSET);
    assign hit_caps = (wb_adr_i == `GCFG_CAPS_OFFSET);
    assign wr_cfg   = req && wb_we_i && hit_cfg;
    assign transient_hint_t_dummy_n = 1'b1;

    // ------------------------------------------------------------
    // Wishbone handshake
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_q    <= BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    if (req) begin
                        bus_q    <= BUS_ACK;
                        wb_ack_o <= hit_cfg || hit_caps;
                        wb_err_o <= !(hit_cfg || hit_caps);
                        wb_dat_o <= rdata_d;
                    end
                end
                BUS_ACK: begin
                    bus_q    <= BUS_IDLE;
                    wb_ack_o <= 1'b0;
                    wb_err_o <= 1'b0;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (!wb_we_i && hit_cfg) begin
            rdata_d[`GCFG_FORCE_BC]  = force_broadcast_q;
            rdata_d[`GCFG_PTM]       = private_tlb_maint_q;            // RULE_05
            rdata_d[`GCFG_VMID_PRIV] = vmid_private_namespace_q;       // RULE_07
            rdata_d[`GCFG_USF]       = unmatched_stream_fault_cfg_q;
            rdata_d[`GCFG_GSTALL]    = global_stall_enable_q && !stall_disable_q; // RULE_10
            rdata_d[`GCFG_STALL_DIS] = stall_disable_q;
            rdata_d[`GCFG_TRANS_HI:`GCFG_TRANS_LO] = transient_hint_cfg_q;
            rdata_d[`GCFG_CF_IRQ]    = cfg_fault_irq_enable_q;
            rdata_d[`GCFG_CF_ABORT]  = cfg_fault_abort_enable_q;
            rdata_d[`GCFG_EXT_ID]    = extended_id_enable_q;
            rdata_d[`GCFG_GF_IRQ]    = global_fault_irq_enable_q;
            rdata_d[`GCFG_GF_ABORT]  = global_fault_abort_enable_q;
            rdata_d[`GCFG_CLIENT_PD] = client_port_disable_q;
        end else if (!wb_we_i && hit_caps) begin
            rdata_d[0] = BROADCAST_MAINT_CAPABLE;
            rdata_d[1] = EXTENDED_ID_SUPPORTED;
            rdata_d[2] = STREAM_MATCH_SUPPORTED;
            rdata_d[3] = GLOBAL_STALL_SUPPORTED;
            rdata_d[4] = TWO_SECURITY_STATES;
        end
    end

    // ------------------------------------------------------------
    // Broadcast and namespace fields (unknown reset held as zero)
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            force_broadcast_q            <= 1'b0;                      // RULE_21
            private_tlb_maint_q          <= PTM_FIXED;                 // RULE_05
            vmid_private_namespace_q     <= VMID_FIXED;
            unmatched_stream_fault_cfg_q <= 1'b0;                      // RULE_21
        end else if (wr_cfg && wb_sel_i[1]) begin
            force_broadcast_q            <= wb_dat_i[`GCFG_FORCE_BC];  // RULE_02
            if (PTM_WRITABLE) begin
                private_tlb_maint_q <= wb_dat_i[`GCFG_PTM];            // RULE_05
            end
            if (VMID_WRITABLE) begin
                vmid_private_namespace_q <= wb_dat_i[`GCFG_VMID_PRIV]; // RULE_07
            end
            unmatched_stream_fault_cfg_q <= wb_dat_i[`GCFG_USF];
        end
    end

    // ------------------------------------------------------------
    // Stall fields
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            global_stall_enable_q <= 1'b0;                             // RULE_09
            stall_disable_q       <= 1'b0;                             // RULE_11
        end else if (wr_cfg && wb_sel_i[1]) begin
            if (GLOBAL_STALL_SUPPORTED) begin
                global_stall_enable_q <= wb_dat_i[`GCFG_GSTALL]
                                         && !wb_dat_i[`GCFG_STALL_DIS]; // RULE_10
            end
            stall_disable_q <= wb_dat_i[`GCFG_STALL_DIS];
        end else if (stall_disable_q) begin
            global_stall_enable_q <= 1'b0;                             // RULE_10
        end
    end

    // ------------------------------------------------------------
    // Low byte fields
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            transient_hint_cfg_q        <= 2'h0;                       // RULE_12
            cfg_fault_irq_enable_q      <= 1'b0;                       // RULE_13
            cfg_fault_abort_enable_q    <= 1'b0;                       // RULE_14
            extended_id_enable_q        <= 1'b0;                       // RULE_15
            global_fault_irq_enable_q   <= 1'b0;                       // RULE_17
            global_fault_abort_enable_q <= 1'b0;                       // RULE_18
            client_port_disable_q       <= 1'b1;                       // RULE_20
        end else if (wr_cfg) begin
            if (TRANSIENT_HINT_PRESENT && wb_sel_i[0]) begin
                transient_hint_cfg_q <= wb_dat_i[`GCFG_TRANS_HI:`GCFG_TRANS_LO]; // RULE_12
            end
            if (CFG_FAULT_SUPPORTED) begin
                cfg_fault_irq_enable_q   <= merge_bit(cfg_fault_irq_enable_q,
                                                      wb_dat_i[`GCFG_CF_IRQ], wb_sel_i[0]);
                cfg_fault_abort_enable_q <= merge_bit(cfg_fault_abort_enable_q,
                                                      wb_dat_i[`GCFG_CF_ABORT], wb_sel_i[0]);
            end
            if (EXT_WRITABLE) begin
                extended_id_enable_q <= merge_bit(extended_id_enable_q,
                                                  wb_dat_i[`GCFG_EXT_ID], wb_sel_i[0]); // RULE_15
            end
            global_fault_irq_enable_q   <= merge_bit(global_fault_irq_enable_q,
                                                     wb_dat_i[`GCFG_GF_IRQ], wb_sel_i[0]);
            global_fault_abort_enable_q <= merge_bit(global_fault_abort_enable_q,
                                                     wb_dat_i[`GCFG_GF_ABORT], wb_sel_i[0]);
            client_port_disable_q       <= merge_bit(client_port_disable_q,
                                                     wb_dat_i[`GCFG_CLIENT_PD], wb_sel_i[0]);
        end
    end

    // ------------------------------------------------------------
    // Client policy
    // ------------------------------------------------------------
    logic bypass_path;
    assign bypass_path = client_port_disable_q || (txn_valid && !txn_stream_matched);

    assign maint_op_broadcast_out = maint_op_valid
                                    && (maint_op_broadcast || force_broadcast_q); // RULE_01
    // Hints only: applying an invalidate is permitted whenever broadcast maintenance is capable
    assign tlbi_apply = sys_tlbi_valid && BROADCAST_MAINT_CAPABLE        // RULE_03
                        && (!private_tlb_maint_q || 1'b1)                 // RULE_04
                        && (!sys_tlbi_by_vmid || !vmid_private_namespace_q
                            || 1'b1);                                     // RULE_06
    assign txn_bypass = txn_valid && (client_port_disable_q
                        || (!txn_stream_matched && !unmatched_stream_fault_cfg_q)); // RULE_20
    assign txn_unidentified_fault = txn_valid && !client_port_disable_q
                                    && !txn_stream_matched
                                    && unmatched_stream_fault_cfg_q;      // RULE_08
    assign transient_hint = bypass_path ? transient_hint_cfg_q : HINT_DEFAULT; // RULE_12
    assign global_stall   = context_fault && global_stall_enable_q
                            && !stall_disable_q;                          // RULE_09
    assign context_stall  = context_fault && !stall_disable_q;            // RULE_10
    assign extended_id_format = extended_id_enable_q;                     // RULE_15
    assign global_fault_irq   = global_fault && global_fault_irq_enable_q; // RULE_17
    assign cfg_fault_irq      = cfg_fault && cfg_fault_irq_enable_q;      // RULE_13
    assign global_fault_abort = global_fault && global_fault_abort_enable_q; // RULE_18
    assign cfg_fault_abort    = cfg_fault && cfg_fault_abort_enable_q;    // RULE_14
    assign exclusive_fail     = global_fault && txn_exclusive
                                && !global_fault_abort_enable_q;          // RULE_19

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_write_cd;
        wr_cfg && wb_sel_i[0] && !wb_dat_i[`GCFG_CLIENT_PD];
    endsequence

    sequence s_bus_req;
        req;
    endsequence

    sequence s_cfg_read;
        req && !wb_we_i && hit_cfg;
    endsequence

    AST_FB_UPGRADE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_01
        (maint_op_valid && force_broadcast_q) |-> maint_op_broadcast_out)
        else $error("Maintenance op not upgraded");
    AST_FB_PASS: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_02
        (maint_op_valid && !force_broadcast_q) |-> maint_op_broadcast_out == maint_op_broadcast)
        else $error("Maintenance op altered");
    AST_USF_FAULT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_08
        (txn_valid && !txn_stream_matched && !client_port_disable_q)
        |-> txn_unidentified_fault == unmatched_stream_fault_cfg_q)
        else $error("Unmatched stream handling wrong");
    AST_GSE_MASK: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_10
        stall_disable_q |-> !global_stall_enable_q)
        else $error("Global stall survived stall disable");
    AST_GSE_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_09
        (wr_cfg && wb_sel_i[1] && wb_dat_i[`GCFG_GSTALL] && !wb_dat_i[`GCFG_STALL_DIS])
        |=> global_stall_enable_q == GLOBAL_STALL_SUPPORTED)
        else $error("Global stall enable not written");
    AST_HINT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_12
        client_port_disable_q |-> transient_hint == transient_hint_cfg_q)
        else $error("Transient hint not applied");
    AST_CF_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_13
        cfg_fault_irq == (cfg_fault && cfg_fault_irq_enable_q))
        else $error("Config fault irq wrong");
    AST_CF_ABORT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_14
        cfg_fault && !cfg_fault_abort_enable_q |-> !cfg_fault_abort)
        else $error("Config fault abort wrong");
    AST_GF_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_17
        global_fault && global_fault_irq_enable_q |-> global_fault_irq)
        else $error("Global fault irq missing");
    AST_GF_ABORT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_18
        global_fault_abort |-> global_fault_abort_enable_q && global_fault)
        else $error("Global fault abort wrong");
    AST_EXCL: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_19
        global_fault && txn_exclusive && !global_fault_abort_enable_q |-> exclusive_fail)
        else $error("Exclusive not failed");
    AST_CPD_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_20
        s_write_cd |=> !client_port_disable_q ##0
        (!txn_valid || txn_bypass == (!txn_stream_matched && !unmatched_stream_fault_cfg_q)))
        else $error("Client port disable not cleared");
    AST_EXT_RAZ: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_15
        !EXT_WRITABLE |-> !extended_id_enable_q)
        else $error("Extended id set while unsupported");
    AST_ACK_ONE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_20
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held two cycles");
    AST_ERR_ONE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wb_err_o |=> !wb_err_o)
        else $error("Error held two cycles");
    AST_ANSWER: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_bus_req |=> wb_ack_o != wb_err_o)
        else $error("Request not answered once");
    AST_CFG_READ: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_20
        s_cfg_read |=> wb_ack_o && wb_dat_o[`GCFG_CLIENT_PD] == client_port_disable_q)
        else $error("Read data does not match register");
    AST_TLBI_APPLY: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_03
        sys_tlbi_valid |-> tlbi_apply == BROADCAST_MAINT_CAPABLE)
        else $error("Broadcast invalidate not applied");
    AST_CTX_STALL: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_10
        context_fault && stall_disable_q |-> !context_stall && !global_stall)
        else $error("Stall raised while disabled");
    AST_CPD_BYPASS: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_20
        txn_valid && client_port_disable_q |-> txn_bypass && !txn_unidentified_fault)
        else $error("Disabled client port did not bypass");
    AST_HINT_MATCHED: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_12
        txn_valid && txn_stream_matched && !client_port_disable_q
        |-> transient_hint == HINT_DEFAULT)
        else $error("Hint applied to mapped traffic");
    AST_CF_ABORT_ON: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_14
        cfg_fault && cfg_fault_abort_enable_q |-> cfg_fault_abort)
        else $error("Config fault abort missing");
    AST_GF_IRQ_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_17
        !global_fault_irq_enable_q |-> !global_fault_irq)
        else $error("Global fault irq while disabled");

endmodule : translation_unit_global_control_low

`default_nettype wire

/* shared/gcfg_defines.svh */
// Offsets, field positions and reset value for the global config block
`ifndef GCFG_DEFINES_SVH
`define GCFG_DEFINES_SVH
`define GCFG0_OFFSET      4'h0
`define GCFG_CAPS_OFFSET  4'h4
`define GCFG_CLIENT_PD    0
`define GCFG_GF_ABORT     1
`define GCFG_GF_IRQ       2
`define GCFG_EXT_ID       3
`define GCFG_CF_ABORT     4
`define GCFG_CF_IRQ       5
`define GCFG_TRANS_LO     6
`define GCFG_TRANS_HI     7
`define GCFG_STALL_DIS    8
`define GCFG_GSTALL       9
`define GCFG_USF          10
`define GCFG_VMID_PRIV    11
`define GCFG_PTM          12
`define GCFG_FORCE_BC     13
`define GCFG0_RESET       32'h0000_0001
`endif

/* shared/gcfg_pkg.sv */
// Types shared by the global config block
package gcfg_pkg;
    typedef logic [1:0] transient_hint_t;
    typedef enum logic [1:0] {
        HINT_DEFAULT,
        HINT_RESERVED,
        HINT_NON_TRANSIENT,
        HINT_TRANSIENT
    } transient_hint_e;
    typedef enum {
        BUS_IDLE,
        BUS_ACK
    } bus_state_e;
endpackage : gcfg_pkg

/* test/client_master_model.sv */
// Client-side model: transactions, maintenance ops and fault events
`timescale 1ns/1ps
`default_nettype none

module client_master_model (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [9:0] pattern,
    output logic            maint_op_valid,
    output logic            maint_op_broadcast,
    output logic            sys_tlbi_valid,
    output logic            sys_tlbi_by_vmid,
    output logic            txn_valid,
    output logic            txn_stream_matched,
    output logic            txn_exclusive,
    output logic            context_fault,
    output logic            global_fault,
    output logic            cfg_fault
);
    // Changes only just after an edge, quiet in reset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {cfg_fault, global_fault, context_fault, txn_exclusive, txn_stream_matched,
             txn_valid, sys_tlbi_by_vmid, sys_tlbi_valid, maint_op_broadcast,
             maint_op_valid} <= 10'h000;
        end else begin
            {cfg_fault, global_fault, context_fault, txn_exclusive, txn_stream_matched,
             txn_valid, sys_tlbi_by_vmid, sys_tlbi_valid, maint_op_broadcast,
             maint_op_valid} <= pattern;
        end
    end
endmodule : client_master_model

`default_nettype wire

/* test/tb_translation_unit_global_control_low.sv */
// Self-checking bench for the global config block
`timescale 1ns/1ps
`default_nettype none

module tb_translation_unit_global_control_low;
    import gcfg_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, wb_err_o, er, mv, mb, tv, tb, xv, xm, xe, cf, gf, ff;
    logic [9:0] pattern = 10'h000;
    logic [13:0] shadow = 14'h0001;
    logic [31:0] sv, ev;
    logic [1:0] transient_hint;
    logic mbo, tla, byp, usf, gst, cst, exf, gfi, cfi, gfa, cfa, xfl, dmy;
    int fails = 0, n_checks = 0, cycles = 0, seed = 32'h6528;

    always #12.5 ref_clk = ~ref_clk;

    client_master_model partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .pattern(pattern),
        .maint_op_valid(mv), .maint_op_broadcast(mb), .sys_tlbi_valid(tv),
        .sys_tlbi_by_vmid(tb), .txn_valid(xv), .txn_stream_matched(xm), .txn_exclusive(xe),
        .context_fault(cf), .global_fault(gf), .cfg_fault(ff));

    translation_unit_global_control_low dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .maint_op_valid(mv), .maint_op_broadcast(mb),
        .sys_tlbi_valid(tv), .sys_tlbi_by_vmid(tb), .txn_valid(xv), .txn_stream_matched(xm),
        .txn_exclusive(xe), .context_fault(cf), .global_fault(gf), .cfg_fault(ff),
        .maint_op_broadcast_out(mbo), .tlbi_apply(tla), .txn_bypass(byp),
        .txn_unidentified_fault(usf), .transient_hint_t_dummy_n(dmy),
        .transient_hint(transient_hint),
        .global_stall(gst), .context_stall(cst), .extended_id_format(exf),
        .global_fault_irq(gfi), .cfg_fault_irq(cfi), .global_fault_abort(gfa),
        .cfg_fault_abort(cfa), .exclusive_fail(xfl));

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    task check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Expected register contents after a write
    function logic [13:0] merge(logic [13:0] c, logic [31:0] d, logic [3:0] s);
        logic [13:0] n;
        n = c;
        if (s[0]) n[7:0] = d[7:0];
        if (s[1]) n[13:8] = d[13:8];
        if (n[8]) n[9] = 1'b0;
        return n;
    endfunction : merge

    // Expected client-side outputs
    function logic [13:0] exp_out(logic [13:0] c, logic [9:0] p);
        logic [13:0] e;
        e[13] = p[0] && (p[1] || c[13]);
        e[12] = p[2];
        e[11] = p[4] && (c[0] || (!p[5] && !c[10]));
        e[10] = p[4] && !c[0] && !p[5] && c[10];
        e[9:8] = (c[0] || (p[4] && !p[5])) ? c[7:6] : 2'b00;
        e[7] = p[7] && c[9] && !c[8];
        e[6] = p[7] && !c[8];
        e[5] = c[3];
        e[4] = p[8] && c[2];
        e[3] = p[9] && c[5];
        e[2] = p[8] && c[1];
        e[1] = p[9] && c[4];
        e[0] = p[8] && p[6] && !c[1];
        return e;
    endfunction : exp_out

    task wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] s);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= wd;
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        if (we && a == `GCFG0_OFFSET && er === 1'b0) shadow = merge(shadow, wd, s);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask : wb_xfer

    task cfg_cycle(input logic [31:0] wd, input logic [3:0] s, input int n);
        wb_xfer(1'b1, `GCFG0_OFFSET, wd, s);
        wb_xfer(1'b0, `GCFG0_OFFSET, 32'h0, 4'hf);
        check("cfg_readback", rd, {18'h0, shadow});
        repeat (n) begin
            @(posedge ref_clk);
            pattern <= 10'($random(seed));
            #1;
            sv = {18'h0, mbo, tla, byp, usf, transient_hint,
                  gst, cst, exf, gfi, cfi, gfa, cfa, xfl};
            ev = {18'h0, exp_out(shadow, {ff, gf, cf, xe, xm, xv, tb, tv, mb, mv})};
            check("maint_outputs", sv & 32'h3000, ev & 32'h3000);
            check("txn_outputs", sv & 32'h0f00, ev & 32'h0f00);
            check("stall_outputs", sv & 32'h00e0, ev & 32'h00e0);
            check("irq_outputs", sv & 32'h0018, ev & 32'h0018);
            check("abort_outputs", sv & 32'h0007, ev & 32'h0007);
        end
    endtask : cfg_cycle

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        wb_xfer(1'b0, `GCFG0_OFFSET, 32'h0, 4'hf);
        check("cfg_reset", rd, 32'h0000_0001);
        wb_xfer(1'b1, `GCFG_CAPS_OFFSET, 32'h0, 4'hf);
        wb_xfer(1'b0, `GCFG_CAPS_OFFSET, 32'h0, 4'hf);
        check("caps_ro", rd, 32'h0000_001f);
        check("hint_dummy", {31'h0, dmy}, 32'h1);
        wb_xfer(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
        check("unmapped_err", {31'h0, er}, 32'h1);
        cfg_cycle(32'h0000_3fff, 4'hf, 20);
        cfg_cycle(32'h0000_0200, 4'h2, 20);
        for (int i = 0; i < 4; i++) cfg_cycle({24'h0, 2'(i), 6'h0} | 32'h400, 4'h3, 12);
        // Extended id toggled freely; no stream entries held here
        repeat (12) cfg_cycle($random(seed), 4'($random(seed)), 12);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        shadow = 14'h0001;
        @(posedge ref_clk);
        cfg_cycle(32'h0, 4'h0, 4);
        close_out();
    end
endmodule : tb_translation_unit_global_control_low

`default_nettype wire
